//--- hdl/aux_dma_readout.sv
`timescale 1ns/1ps
module aux_dma_readout
	import aux_dma_pkg::*;
(
	input wire logic mclk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [DATA_W-1:0] pwdata,
	output logic [DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic entry_valid,
	input wire logic entry_stream,
	input wire logic [DATA_W-1:0] entry_data,
	input wire logic replay_underrun,
	output logic dma_valid,
	output logic dma_stream,
	output logic [DATA_W-1:0] dma_offset,
	output logic [DATA_W-1:0] dma_data,
	input wire logic dma_ready,
	input wire logic dma_err,
	output logic card_cmd_valid,
	output logic [DATA_W-1:0] card_cmd,
	output logic data_event
);

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [IDX_W-1:0] idx);
		return a[ADDR_W-1:2] == idx;
	endfunction

	// Assumes len > 0 and step <= len
	function automatic logic [DATA_W-1:0] ring_adv(input logic [DATA_W-1:0] pos,
		input logic [DATA_W-1:0] step, input logic [DATA_W-1:0] len);
		logic [DATA_W-1:0] sum;
		sum = pos + step;
		return (sum >= len) ? sum - len : sum;
	endfunction

	logic [DATA_W-1:0] buf_len, notify_size, wait_limit, wait_cnt;
	logic running, poll_mode, waiting;
	logic flag_block, flag_done, flag_ovr, flag_err, flag_wait_to;
	logic [DATA_W-1:0] user_len [2];
	logic [DATA_W-1:0] user_pos [2];
	logic [DATA_W-1:0] card_len [2];
	logic [DATA_W-1:0] wpos [2];
	logic [DATA_W-1:0] pend [2];
	logic [DATA_W-1:0] next_user_len [2];
	logic [DATA_W-1:0] next_user_pos [2];
	logic [DATA_W-1:0] next_card_len [2];
	logic [DATA_W-1:0] next_wpos [2];
	logic [DATA_W-1:0] next_pend [2];
	logic publish [2];
	logic fill_end [2];
	logic freed_wr [2];
	logic drain_rd [2];
	logic [DATA_W:0] fifo_mem [FIFO_DEPTH];
	logic [PTR_W-1:0] rd_ptr, wr_ptr;
	logic [PTR_W:0] fifo_cnt;
	logic wr_acc, rd_setup, cmd_wr, start_cmd, halt_cmd, wait_cmd, poll_cmd;
	logic mapped, head_stream, beat, push, fifo_full, ovr_evt, err_evt, wait_met;

	assign pready = ce;
	assign wr_acc = ce & psel & penable & pwrite;
	assign rd_setup = ce & psel & ~penable & ~pwrite;
	assign cmd_wr = wr_acc & hit(paddr, IDX_CMD);
	assign halt_cmd = cmd_wr & pwdata[CMD_HALT];
	assign start_cmd = cmd_wr & (pwdata[CMD_START] | pwdata[CMD_POLL]) & ~pwdata[CMD_HALT];
	assign poll_cmd = cmd_wr & pwdata[CMD_POLL];
	assign wait_cmd = cmd_wr & pwdata[CMD_WAIT] & ~pwdata[CMD_HALT];
	assign freed_wr[STREAM_STAMP] = wr_acc & hit(paddr, IDX_STAMP_FREED);
	assign freed_wr[STREAM_SLOW] = wr_acc & hit(paddr, IDX_AUX_FREED);
	assign drain_rd[STREAM_STAMP] = rd_setup & hit(paddr, IDX_STAMP_USER_LEN);
	assign drain_rd[STREAM_SLOW] = rd_setup & hit(paddr, IDX_AUX_USER_LEN);

	// Read-only registers refuse writes and write-only ones refuse reads
	always_comb begin
		mapped = 1'b0;
		if (pwrite) begin
			mapped = hit(paddr, IDX_CMD) | hit(paddr, IDX_AUX_FREED) |
				hit(paddr, IDX_STAMP_FREED) | hit(paddr, IDX_BUF_LEN) |
				hit(paddr, IDX_NOTIFY) | hit(paddr, IDX_WAIT_LIMIT);
		end else begin
			mapped = hit(paddr, IDX_STATUS) | hit(paddr, IDX_AUX_USER_LEN) |
				hit(paddr, IDX_AUX_USER_POS) | hit(paddr, IDX_STAMP_USER_LEN) |
				hit(paddr, IDX_STAMP_USER_POS) | hit(paddr, IDX_BUF_LEN) |
				hit(paddr, IDX_NOTIFY) | hit(paddr, IDX_WAIT_LIMIT);
		end
	end
	assign pslverr = psel & penable & ~mapped;

	// Shared FIFO: entries of both streams in arrival order, tagged by stream
	assign fifo_full = (fifo_cnt == FIFO_FULL_CNT);
	assign push = ce & entry_valid & ~fifo_full;
	assign head_stream = fifo_mem[rd_ptr][DATA_W];
	// Card to host only; offsets start at zero of the buffer
	assign dma_valid = ce & running & (fifo_cnt != '0) & (card_len[head_stream] >= WORD_BYTES);
	assign dma_stream = head_stream;
	assign dma_data = fifo_mem[rd_ptr][DATA_W-1:0];
	assign dma_offset = wpos[head_stream];
	assign beat = dma_valid & dma_ready;
	assign ovr_evt = ce & running & ((entry_valid & fifo_full) | replay_underrun);
	assign err_evt = ce & running & dma_err;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rd_ptr <= '0;
			wr_ptr <= '0;
			fifo_cnt <= '0;
		end else if (ce) begin
			if (halt_cmd) begin // Flushed data is invalid
				rd_ptr <= '0;
				wr_ptr <= '0;
				fifo_cnt <= '0;
			end else begin
				if (push)
					wr_ptr <= wr_ptr + 1'b1;
				if (beat)
					rd_ptr <= rd_ptr + 1'b1;
				fifo_cnt <= fifo_cnt + {4'h0, push} - {4'h0, beat};
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (push)
			fifo_mem[wr_ptr] <= {entry_stream, entry_data};
	end

	// Per-stream ring bookkeeping; no state shared with the sample engine
	always_comb begin
		logic [DATA_W-1:0] inc;
		logic [DATA_W-1:0] fr;
		inc = '0;
		fr = '0;
		for (int s = 0; s < 2; s++) begin
			inc = (beat && head_stream == s[0]) ? WORD_BYTES : '0;
			publish[s] = 1'b0;
			fill_end[s] = 1'b0;
			next_pend[s] = pend[s] + inc;
			next_user_len[s] = user_len[s];
			next_card_len[s] = card_len[s] - inc; // Runs until granted space is used
			next_wpos[s] = ring_adv(wpos[s], inc, buf_len); // Word steps; a stamp spans two
			if (poll_mode && drain_rd[s]) begin // Word granularity drain
				next_user_len[s] = user_len[s] + next_pend[s];
				next_pend[s] = '0;
			end else if (!poll_mode && notify_size != '0 && pend[s] >= notify_size) begin
				next_user_len[s] = user_len[s] + notify_size;
				next_pend[s] = next_pend[s] - notify_size;
				publish[s] = 1'b1;
			end else if (notify_size == '0 && inc != '0 && card_len[s] == WORD_BYTES) begin
				next_user_len[s] = user_len[s] + next_pend[s];
				next_pend[s] = '0;
				fill_end[s] = 1'b1;
			end
			fr = (pwdata > next_user_len[s]) ? next_user_len[s] : pwdata;
			if (!freed_wr[s])
				fr = '0;
			next_user_len[s] = next_user_len[s] - fr;
			next_user_pos[s] = ring_adv(user_pos[s], fr, buf_len);
			next_card_len[s] = next_card_len[s] + fr;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			for (int s = 0; s < 2; s++) begin
				user_len[s] <= '0;
				user_pos[s] <= '0;
				card_len[s] <= '0;
				wpos[s] <= '0;
				pend[s] <= '0;
			end
		end else if (ce) begin
			for (int s = 0; s < 2; s++) begin
				if (start_cmd) begin // Fresh ring: nothing for the user, all for the card
					user_len[s] <= '0;
					user_pos[s] <= '0;
					card_len[s] <= buf_len;
					wpos[s] <= '0;
					pend[s] <= '0;
				end else if (halt_cmd) begin
					pend[s] <= '0;
				end else begin
					user_len[s] <= next_user_len[s];
					user_pos[s] <= next_user_pos[s];
					card_len[s] <= next_card_len[s];
					wpos[s] <= next_wpos[s];
					pend[s] <= next_pend[s];
				end
			end
		end
	end

	// Run control; poll and DMA share one engine, software picks one
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			running <= 1'b0;
			poll_mode <= 1'b0;
		end else if (ce) begin
			if (halt_cmd || ovr_evt || err_evt || fill_end[0] || fill_end[1]) begin
				running <= 1'b0;
			end else if (start_cmd) begin
				running <= 1'b1;
				poll_mode <= poll_cmd;
			end
		end
	end

	// Sticky flags cleared by a start; a set in the same cycle wins
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			flag_block <= 1'b0;
			flag_done <= 1'b0;
			flag_ovr <= 1'b0;
			flag_err <= 1'b0;
		end else if (ce) begin
			flag_block <= publish[0] | publish[1] |
				(flag_block & ~start_cmd & ~wait_cmd);
			flag_done <= fill_end[0] | fill_end[1] | (flag_done & ~start_cmd);
			flag_ovr <= ovr_evt | (flag_ovr & ~start_cmd);
			flag_err <= err_evt | (flag_err & ~start_cmd);
		end
	end

	assign wait_met = flag_done | flag_block | publish[0] | publish[1] | fill_end[0] | fill_end[1];

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			waiting <= 1'b0;
			wait_cnt <= '0;
			flag_wait_to <= 1'b0;
		end else if (ce) begin
			if (wait_cmd) begin
				waiting <= 1'b1;
				wait_cnt <= '0;
				flag_wait_to <= 1'b0;
			end else if (waiting) begin
				wait_cnt <= wait_cnt + 32'h0000_0001;
				if (wait_met || halt_cmd || !running) begin
					waiting <= 1'b0;
				end else if (wait_limit != '0 && wait_cnt == wait_limit - 32'h0000_0001) begin
					waiting <= 1'b0;
					flag_wait_to <= 1'b1;
				end
			end
		end
	end

	// Non-auxiliary codes of the same write go on to the card and sample logic
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			card_cmd_valid <= 1'b0;
			card_cmd <= '0;
			data_event <= 1'b0;
		end else if (ce) begin
			card_cmd_valid <= cmd_wr & ((pwdata & ~AUX_CMD_MASK) != '0);
			card_cmd <= pwdata & ~AUX_CMD_MASK;
			data_event <= publish[0] | publish[1] | fill_end[0] | fill_end[1];
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			buf_len <= BUF_LEN_RST;
			notify_size <= NOTIFY_RST;
			wait_limit <= WAIT_LIMIT_RST;
		end else if (wr_acc) begin
			if (hit(paddr, IDX_BUF_LEN))
				buf_len <= pwdata;
			if (hit(paddr, IDX_NOTIFY))
				notify_size <= pwdata;
			if (hit(paddr, IDX_WAIT_LIMIT))
				wait_limit <= pwdata;
		end
	end

	// Read data is captured in the setup cycle so it stands through the access cycle
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			prdata <= '0;
		end else if (rd_setup) begin
			prdata <= '0;
			if (hit(paddr, IDX_STATUS)) begin
				prdata[ST_BLOCK] <= flag_block;
				prdata[ST_DONE] <= flag_done;
				prdata[ST_OVERRUN] <= flag_ovr;
				prdata[ST_ERROR] <= flag_err;
				prdata[ST_WAIT_TIMEOUT] <= flag_wait_to;
				prdata[ST_RUNNING] <= running;
				prdata[ST_POLL] <= poll_mode;
				prdata[ST_WAITING] <= waiting;
			end
			if (hit(paddr, IDX_STAMP_USER_LEN))
				prdata <= next_user_len[STREAM_STAMP];
			if (hit(paddr, IDX_AUX_USER_LEN))
				prdata <= next_user_len[STREAM_SLOW];
			if (hit(paddr, IDX_STAMP_USER_POS))
				prdata <= user_pos[STREAM_STAMP];
			if (hit(paddr, IDX_AUX_USER_POS))
				prdata <= user_pos[STREAM_SLOW];
			if (hit(paddr, IDX_BUF_LEN))
				prdata <= buf_len;
			if (hit(paddr, IDX_NOTIFY))
				prdata <= notify_size;
			if (hit(paddr, IDX_WAIT_LIMIT))
				prdata <= wait_limit;
		end
	end

	property p_start_fresh;
		@(posedge mclk) disable iff (!rstn)
		start_cmd |=> running && user_len[0] == '0 && user_len[1] == '0 &&
			card_len[0] == buf_len && card_len[1] == buf_len;
	endproperty
	a_start_fresh: assert property (p_start_fresh) else $error("start did not reset ring");

	property p_halt;
		@(posedge mclk) disable iff (!rstn)
		halt_cmd |=> !running && fifo_cnt == '0 && !dma_valid;
	endproperty
	a_halt: assert property (p_halt) else $error("halt left transfer running");

	property p_overrun;
		@(posedge mclk) disable iff (!rstn)
		(running && ce && entry_valid && fifo_full) |=> flag_ovr && !running;
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun not flagged or not stopped");

	property p_error;
		@(posedge mclk) disable iff (!rstn)
		err_evt |=> flag_err && !running [*2];
	endproperty
	a_error: assert property (p_error) else $error("internal error not flagged");

	property p_block_event;
		@(posedge mclk) disable iff (!rstn)
		(publish[0] && !start_cmd) |=> flag_block && data_event &&
			user_len[0] >= $past(notify_size);
	endproperty
	a_block_event: assert property (p_block_event) else $error("block not announced");

	property p_done;
		@(posedge mclk) disable iff (!rstn)
		$rose(flag_done) |-> $past(notify_size) == '0 && !running;
	endproperty
	a_done: assert property (p_done) else $error("done flag with nonzero notify");

	property p_timeout;
		@(posedge mclk) disable iff (!rstn)
		$rose(flag_wait_to) |-> !waiting && $past(waiting) && $past(wait_limit) != '0;
	endproperty
	a_timeout: assert property (p_timeout) else $error("timeout without a wait");

	property p_dma_hold;
		@(posedge mclk) disable iff (!rstn)
		(dma_valid && !dma_ready && !halt_cmd && !ovr_evt && !err_evt && !start_cmd) ##1 ce |->
			dma_valid && $stable(dma_data) && $stable(dma_offset);
	endproperty
	a_dma_hold: assert property (p_dma_hold) else $error("dma request dropped");

	property p_card_cmd;
		@(posedge mclk) disable iff (!rstn)
		(cmd_wr && (pwdata & ~AUX_CMD_MASK) != '0) |=>
			card_cmd_valid && card_cmd == $past(pwdata & ~AUX_CMD_MASK);
	endproperty
	a_card_cmd: assert property (p_card_cmd) else $error("card code not forwarded");
endmodule

//--- include/aux_dma_pkg.sv
package aux_dma_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int IDX_W = 10;

	// Register indices; the byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_CMD = 10'h064;
	localparam logic [IDX_W-1:0] IDX_STATUS = 10'h06E;
	localparam logic [IDX_W-1:0] IDX_AUX_USER_LEN = 10'h0D2;
	localparam logic [IDX_W-1:0] IDX_AUX_USER_POS = 10'h0D3;
	localparam logic [IDX_W-1:0] IDX_AUX_FREED = 10'h0D4;
	localparam logic [IDX_W-1:0] IDX_STAMP_USER_LEN = 10'h0DC;
	localparam logic [IDX_W-1:0] IDX_STAMP_USER_POS = 10'h0DD;
	localparam logic [IDX_W-1:0] IDX_STAMP_FREED = 10'h0DE;
	localparam logic [IDX_W-1:0] IDX_BUF_LEN = 10'h0F0;
	localparam logic [IDX_W-1:0] IDX_NOTIFY = 10'h0F1;
	localparam logic [IDX_W-1:0] IDX_WAIT_LIMIT = 10'h0F2;

	// Command word bit positions
	localparam int CMD_START = 20;
	localparam int CMD_WAIT = 21;
	localparam int CMD_HALT = 22;
	localparam int CMD_POLL = 23;
	localparam logic [DATA_W-1:0] AUX_CMD_MASK = 32'h00F0_0000;

	// Status word bit positions
	localparam int ST_BLOCK = 12;
	localparam int ST_DONE = 13;
	localparam int ST_OVERRUN = 14;
	localparam int ST_ERROR = 15;
	localparam int ST_WAIT_TIMEOUT = 16;
	localparam int ST_RUNNING = 17;
	localparam int ST_POLL = 18;
	localparam int ST_WAITING = 19;

	localparam logic [DATA_W-1:0] BUF_LEN_RST = 32'h0000_1000;
	localparam logic [DATA_W-1:0] NOTIFY_RST = 32'h0000_0000;
	localparam logic [DATA_W-1:0] WAIT_LIMIT_RST = 32'h0000_0000;
	localparam logic [DATA_W-1:0] WORD_BYTES = 32'h0000_0004;

	localparam int FIFO_DEPTH = 16;
	localparam int PTR_W = 4;
	localparam logic [PTR_W:0] FIFO_FULL_CNT = 5'h10;
	localparam logic STREAM_STAMP = 1'b0;
	localparam logic STREAM_SLOW = 1'b1;
endpackage

//--- test/host_mem_model.sv
`timescale 1ns/1ps
module host_mem_model
	import aux_dma_pkg::*;
(
	input wire logic mclk,
	input wire logic rstn,
	input wire logic dma_valid,
	input wire logic dma_stream,
	input wire logic [DATA_W-1:0] dma_offset,
	input wire logic [DATA_W-1:0] dma_data,
	output logic dma_ready,
	output logic dma_err,
	input wire logic stall,
	input wire logic slow,
	input wire logic err_req
);
	logic [DATA_W-1:0] mem [2][256];
	// Slow mode accepts every other cycle so the engine must hold its request
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			dma_ready <= 1'b0;
		end else begin
			dma_ready <= !stall && (!slow || !dma_ready);
		end
	end
	// Host ring only ever receives writes from the card
	always_ff @(posedge mclk) begin
		if (dma_valid && dma_ready) begin
			mem[dma_stream][dma_offset[9:2]] <= dma_data;
		end
	end
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			dma_err <= 1'b0;
		end else begin
			dma_err <= err_req;
		end
	end
endmodule

//--- test/aux_dma_readout_tb_top.sv
`timescale 1ns/1ps
module aux_dma_readout_tb_top import aux_dma_pkg::*;;
	localparam logic [DATA_W-1:0] ALL = 32'hFFFF_FFFF;
	logic mclk, rstn, ce, psel, penable, pwrite, pready, pslverr, err;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata, prdata, entry_data, dma_offset, dma_data, card_cmd, rd, last_cmd;
	logic entry_valid, entry_stream, replay_underrun, dma_valid, dma_stream, dma_ready, dma_err;
	logic card_cmd_valid, data_event, stall, slow, err_req;
	int failures, cmp_count, events, e0, n;
	logic [DATA_W-1:0] sent [$];

	aux_dma_readout i_dut (.mclk(mclk), .rstn(rstn), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .entry_valid(entry_valid), .entry_stream(entry_stream),
		.entry_data(entry_data), .replay_underrun(replay_underrun), .dma_valid(dma_valid),
		.dma_stream(dma_stream), .dma_offset(dma_offset), .dma_data(dma_data),
		.dma_ready(dma_ready), .dma_err(dma_err), .card_cmd_valid(card_cmd_valid),
		.card_cmd(card_cmd), .data_event(data_event));
	host_mem_model i_host (.mclk(mclk), .rstn(rstn), .dma_valid(dma_valid),
		.dma_stream(dma_stream), .dma_offset(dma_offset), .dma_data(dma_data),
		.dma_ready(dma_ready), .dma_err(dma_err), .stall(stall), .slow(slow), .err_req(err_req));

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		if (data_event === 1'b1) events++;
		if (card_cmd_valid === 1'b1) last_cmd = card_cmd;
	end

	function automatic logic [DATA_W-1:0] b(input int i);
		return 32'h1 << i;
	endfunction
	function automatic logic [DATA_W-1:0] exp_len(input int words, input int step);
		return 32'((words * 4 / step) * step);
	endfunction
	task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [IDX_W-1:0] idx, input logic [DATA_W-1:0] d);
		int k;
		k = 0;
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
			k++;
		end while (pready !== 1'b1 && k < 100);
		if (k >= 100) failures++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [IDX_W-1:0] idx, input logic [DATA_W-1:0] d);
		apb(1'b1, idx, d);
	endtask
	task automatic rchk(input logic [IDX_W-1:0] idx, input logic [DATA_W-1:0] m,
		input logic [DATA_W-1:0] exp);
		apb(1'b0, idx, 32'h0);
		chk(rd & m, exp);
	endtask
	task automatic push(input logic s, input int cnt);
		logic [DATA_W-1:0] v;
		repeat (cnt) begin
			v = $urandom;
			sent.push_back(v);
			@(posedge mclk);
			entry_valid <= 1'b1;
			entry_stream <= s;
			entry_data <= v;
		end
		@(posedge mclk);
		entry_valid <= 1'b0;
	endtask
	// Halt first so leftovers of the previous test never leak into the next one
	task automatic start(input logic [DATA_W-1:0] ntf, input logic [DATA_W-1:0] len);
		wr(IDX_CMD, b(CMD_HALT));
		wr(IDX_BUF_LEN, len);
		wr(IDX_NOTIFY, ntf);
		wr(IDX_CMD, b(CMD_START));
		sent.delete();
	endtask
	task automatic tend(input string s);
		$display("Test %s finished", s);
	endtask
	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Whole sequence needs about 400 cycles; fifty times that means a hang
	initial begin
		repeat (20000) @(posedge mclk);
		failures++;
		print_verdict();
	end

	initial begin
		{ce, rstn, psel, penable, pwrite, entry_valid, entry_stream} = 7'b1000000;
		{replay_underrun, stall, slow, err_req} = 4'h0;
		paddr = '0;
		pwdata = '0;
		entry_data = '0;
		last_cmd = '0;
		failures = 0;
		cmp_count = 0;
		events = 0;
		void'($urandom(69));
		repeat (8) @(posedge mclk);
		rstn <= 1'b1;
		rchk(IDX_STATUS, 32'h000F_F000, 32'h0);
		apb(1'b0, IDX_CMD, 32'h0);
		chk(32'(err), 32'h1);
		apb(1'b1, IDX_STATUS, 32'h0);
		chk(32'(err), 32'h1);
		apb(1'b0, 10'h3FF, 32'h0);
		chk({rd[30:0], err}, 32'h1);
		tend("access");
		start(32'h0, 32'h10);
		rchk(IDX_STAMP_USER_LEN, ALL, 32'h0);
		push(STREAM_STAMP, 4);
		repeat (20) @(posedge mclk);
		rchk(IDX_STATUS, b(ST_DONE) | b(ST_RUNNING) | b(ST_BLOCK), b(ST_DONE));
		rchk(IDX_STAMP_USER_LEN, ALL, 32'h10);
		for (int k = 0; k < 4; k++) chk(i_host.mem[0][k], sent[k]);
		tend("whole buffer");
		slow <= 1'b1;
		start(32'h8, 32'h40);
		e0 = events;
		n = 2 + $urandom % 5;
		push(STREAM_STAMP, n);
		push(STREAM_SLOW, 2);
		repeat (40) @(posedge mclk);
		rchk(IDX_STAMP_USER_LEN, ALL, exp_len(n, 8));
		rchk(IDX_AUX_USER_LEN, ALL, exp_len(2, 8));
		rchk(IDX_STATUS, b(ST_BLOCK), b(ST_BLOCK));
		chk(32'(events - e0), 32'(n / 2 + 1));
		chk(i_host.mem[1][1], sent[n + 1]);
		wr(IDX_STAMP_FREED, 32'h8);
		rchk(IDX_STAMP_USER_LEN, ALL, exp_len(n, 8) - 32'h8);
		rchk(IDX_STAMP_USER_POS, ALL, 32'h8);
		slow <= 1'b0;
		tend("notify blocks");
		wr(IDX_WAIT_LIMIT, 32'd20);
		start(32'h8, 32'h40);
		wr(IDX_CMD, b(CMD_WAIT));
		rchk(IDX_STATUS, b(ST_WAITING), b(ST_WAITING));
		repeat (30) @(posedge mclk);
		rchk(IDX_STATUS, b(ST_WAIT_TIMEOUT) | b(ST_WAITING), b(ST_WAIT_TIMEOUT));
		wr(IDX_WAIT_LIMIT, 32'h0);
		wr(IDX_CMD, b(CMD_WAIT));
		push(STREAM_STAMP, 2);
		repeat (20) @(posedge mclk);
		rchk(IDX_STATUS, b(ST_WAITING) | b(ST_BLOCK), b(ST_BLOCK));
		tend("wait");
		stall <= 1'b1;
		start(32'h8, 32'h40);
		push(STREAM_STAMP, 2);
		wr(IDX_CMD, b(CMD_HALT) | 32'h4);
		repeat (2) @(posedge mclk);
		chk(last_cmd, 32'h4);
		rchk(IDX_STATUS, b(ST_RUNNING), 32'h0);
		rchk(IDX_STAMP_USER_LEN, ALL, 32'h0);
		start(32'h8, 32'h40);
		push(STREAM_STAMP, 20);
		repeat (3) @(posedge mclk);
		rchk(IDX_STATUS, b(ST_OVERRUN) | b(ST_RUNNING), b(ST_OVERRUN));
		stall <= 1'b0;
		start(32'h8, 32'h40);
		replay_underrun <= 1'b1;
		@(posedge mclk);
		replay_underrun <= 1'b0;
		repeat (3) @(posedge mclk);
		rchk(IDX_STATUS, b(ST_OVERRUN), b(ST_OVERRUN));
		start(32'h8, 32'h40);
		err_req <= 1'b1;
		@(posedge mclk);
		err_req <= 1'b0;
		repeat (4) @(posedge mclk);
		rchk(IDX_STATUS, b(ST_ERROR) | b(ST_RUNNING), b(ST_ERROR));
		tend("halt and faults");
		wr(IDX_CMD, b(CMD_HALT));
		wr(IDX_CMD, b(CMD_POLL));
		rchk(IDX_STATUS, b(ST_POLL), b(ST_POLL));
		push(STREAM_SLOW, 1);
		repeat (10) @(posedge mclk);
		rchk(IDX_AUX_USER_LEN, ALL, WORD_BYTES);
		tend("poll");
		// An entry offered while the clock enable is low must not be taken
		@(posedge mclk);
		ce <= 1'b0;
		entry_valid <= 1'b1;
		entry_stream <= STREAM_SLOW;
		@(posedge mclk);
		entry_valid <= 1'b0;
		chk(32'(pready), 32'h0);
		repeat (2) @(posedge mclk);
		ce <= 1'b1;
		rchk(IDX_AUX_USER_LEN, ALL, WORD_BYTES);
		tend("clock enable");
		print_verdict();
	end
endmodule
